/* File: rtl/aei_alarm_top.sv */
// Alarm lamp, relay, status words and error level output
`timescale 1ns/1ps
module aei_alarm_top
  import aei_pkg::*;
#(
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  // Error reports from fault detection
  input  wire aei_err_t     i_err,
  // Machine and fieldbus control
  input  wire logic         i_start,
  input  wire logic         i_error_clear_request,
  input  wire logic         i_auto_zero_calibration,
  input  wire logic         i_standby_flag,
  // Configuration
  input  wire logic         i_relay_inverted,
  input  wire logic         i_range_500,
  // Measured temperature
  input  wire logic [15:0]  i_temp_c,
  // Indicators
  output logic              o_alarm_lamp,
  output logic              o_alarm_relay,
  // Cyclic data words
  output logic [15:0]       o_word0_temp,
  output aei_status_t       o_status,
  output logic [15:0]       o_word2_code,
  // Actual-value output in millivolts
  output logic [13:0]       o_aout_mv
);

  // Error level for a code
  function automatic logic [13:0] level_of(input logic [9:0] c);
    if (c == 10'd101) return MV_0_66;                         // see R17
    if (c == 10'd102) return MV_1_33;                         // see R17
    if (c == 10'd103) return MV_2_00;                         // see R17
    if (c == 10'd107 || c == 10'd108 || (c >= 10'd307 && c <= 10'd310))
      return MV_2_66;                                         // see R18
    if (c >= 10'd201 && c <= 10'd203) return MV_3_33;         // see R19
    if (c == 10'd304 || c == 10'd305) return MV_4_00;         // see R20
    if (c >= 10'd900) return MV_4_66;                         // see R21
    if (c == 10'd211) return MV_6_00;                         // see R23
    if (c >= 10'd104 && c <= 10'd106) return MV_5_33;         // see R23
    if (c == 10'd302 || c == 10'd303) return MV_5_33;         // see R23
    if (c == 10'd111) return MV_6_66;                         // see R24
    if (c == 10'd112) return MV_7_33;                         // see R24
    if (c == 10'd113 || c == 10'd114) return MV_8_00;         // see R24
    if (c == 10'd115 || c == 10'd116) return MV_8_66;         // see R24
    return MV_FULL;
  endfunction

  // Clear handshake states
  typedef enum logic [1:0] {
    CLR_IDLE  = 2'b01,
    CLR_ARMED = 2'b10
  } aei_clr_t;

  aei_cls_t    cls_q;
  logic [9:0]  code_q;
  logic        start_seen_q;
  aei_clr_t    clr_q;
  logic        fast_ph_q;
  logic        slow_ph_q;
  logic        fast_tick;
  logic        slow_tick;
  aei_cls_t    new_cls;
  logic        take_new;
  logic        clear_now;
  logic        warn_live;
  logic [13:0] level;
  logic [13:0] temp_mv;

  // Blink dividers, one enable per half wave
  aei_half_div #(.HALF_CYC(FAST_HALF)) u_fast (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .o_tick    (fast_tick)
  );
  aei_half_div #(.HALF_CYC(SLOW_HALF)) u_slow (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .o_tick    (slow_tick)
  );

  // Square waves toggle on each half tick, so duty is exactly half
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fast_ph_q <= 1'b0;
      slow_ph_q <= 1'b0;
    end else begin
      if (fast_tick) begin
        fast_ph_q <= ~fast_ph_q;                              // see R25
      end
      if (slow_tick) begin
        slow_ph_q <= ~slow_ph_q;                              // see R25
      end
    end
  end

  // Candidate report and the clear decision
  always_comb begin
    new_cls   = i_err.valid ? cls_of(i_err.code) : CLS_NONE;
    take_new  = (new_cls != CLS_NONE) && (rank_of(new_cls) > rank_of(cls_q)); // see R26
    clear_now = (clr_q == CLR_ARMED) && !i_error_clear_request;             // see R15
    warn_live = (cls_q == CLS_FAST || cls_q == CLS_SLOW) && !start_seen_q;
    level     = level_of(code_q);                                           // see R11
  end

  // Clear request waits for the bit to fall before acting
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      clr_q <= CLR_IDLE;
    end else begin
      case (clr_q)
        CLR_IDLE: begin
          if (i_error_clear_request) begin
            clr_q <= CLR_ARMED;                               // see R15
          end
        end
        CLR_ARMED: begin
          if (!i_error_clear_request) begin
            clr_q <= CLR_IDLE;
          end
        end
        default: clr_q <= CLR_IDLE;
      endcase
    end
  end

  // Held error; a new report in the clear cycle survives the clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cls_q  <= CLS_NONE;                                     // see R14
      code_q <= CODE_RST;
    end else if (i_err.valid && (take_new || (clear_now && new_cls != CLS_NONE))) begin
      cls_q  <= new_cls;                                      // see R26
      code_q <= i_err.code;                                   // see R22
    end else if (clear_now) begin
      cls_q  <= CLS_NONE;                                     // see R14
      code_q <= CODE_RST;
    end
  end

  // Start during a warning turns it into a held fault
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      start_seen_q <= 1'b0;
    end else if (take_new || clear_now) begin
      start_seen_q <= 1'b0;
    end else if (warn_live && i_start) begin
      start_seen_q <= 1'b1;                                   // see R13
    end
  end

  // Temperature scaled to millivolts, clamped to the 0..10 V span
  always_comb begin
    logic [31:0] prod;
    prod    = 32'h00000000;
    temp_mv = MV_RST;
    if (!i_temp_c[15]) begin
      prod = 32'(i_temp_c) * 32'(i_range_500 ? SCALE_500 : SCALE_300);
      if (prod[31:8] >= 24'(MV_FULL)) begin
        temp_mv = MV_FULL;
      end else begin
        temp_mv = prod[21:8];
      end
    end
  end

  // Lamp pattern by class; start promotes a warning to steady
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_lamp <= 1'b0;
    end else begin
      case (cls_q)
        CLS_FAST:   o_alarm_lamp <= start_seen_q | fast_ph_q; // see R1
        CLS_SLOW:   o_alarm_lamp <= start_seen_q | slow_ph_q; // see R2
        CLS_STEADY: o_alarm_lamp <= 1'b1;                     // see R3
        default:    o_alarm_lamp <= 1'b0;
      endcase
    end
  end

  // Relay: reset value follows factory polarity with no error held
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_relay <= 1'b0;
    end else begin
      case (cls_q)
        CLS_FAST, CLS_SLOW: o_alarm_relay <= start_seen_q ^ i_relay_inverted; // see R4 R6
        CLS_STEADY:         o_alarm_relay <= ~i_relay_inverted;              // see R5 R6
        default:            o_alarm_relay <= i_relay_inverted;               // see R6
      endcase
    end
  end

  // Cyclic words for the fieldbus
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_word0_temp <= 16'h0000;
      o_status     <= '0;
      o_word2_code <= 16'h0000;
    end else begin
      if (i_auto_zero_calibration || cls_q != CLS_NONE) begin
        o_word0_temp <= 16'h0000;                             // see R10
      end else begin
        o_word0_temp <= i_temp_c;                             // see R9
      end
      o_status.alarm_flag   <= (cls_q != CLS_NONE);           // see R7
      o_status.warning_flag <= warn_live;                     // see R7
      o_status.standby_flag <= i_standby_flag;
      o_status.rsvd         <= '0;
      o_word2_code          <= 16'(code_q) << CODE_LSB;       // see R8
    end
  end

  // Analogue output: error level, toggle for live warnings, else temperature, or zero in standby
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_aout_mv <= MV_RST;
    end else if (cls_q == CLS_NONE) begin
      o_aout_mv <= i_standby_flag ? MV_RST : temp_mv;
    end else if (warn_live && slow_ph_q) begin
      o_aout_mv <= MV_FULL;                                   // see R12
    end else begin
      o_aout_mv <= level;                                     // see R11 R13
    end
  end

  // Checks
  property p_lamp_steady;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      cls_q == CLS_STEADY |=> o_alarm_lamp;
  endproperty
  a_lamp_steady: assert property (p_lamp_steady) else $error("lamp not steady"); // see R3

  property p_lamp_fast;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (cls_q == CLS_FAST && !start_seen_q) |=> o_alarm_lamp == $past(fast_ph_q);
  endproperty
  a_lamp_fast: assert property (p_lamp_fast) else $error("fast blink wrong"); // see R1

  property p_lamp_slow;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (cls_q == CLS_SLOW && !start_seen_q) |=> o_alarm_lamp == $past(slow_ph_q);
  endproperty
  a_lamp_slow: assert property (p_lamp_slow) else $error("slow blink wrong"); // see R2

  property p_relay_warn;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (warn_live && !i_relay_inverted) |=> !o_alarm_relay;
  endproperty
  a_relay_warn: assert property (p_relay_warn) else $error("relay on in warning"); // see R4

  property p_relay_fault;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      cls_q == CLS_STEADY |=> o_alarm_relay == !$past(i_relay_inverted);
  endproperty
  a_relay_fault: assert property (p_relay_fault) else $error("relay wrong in fault"); // see R5

  property p_relay_inv;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (cls_q == CLS_FAST && start_seen_q && i_relay_inverted) |=> !o_alarm_relay;
  endproperty
  a_relay_inv: assert property (p_relay_inv) else $error("relay not inverted"); // see R6

  property p_alarm_flag;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      cls_q != CLS_NONE |=> o_status.alarm_flag && o_word0_temp == 16'h0000;
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag missing"); // see R7

  property p_code_word;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      1'b1 |=> o_word2_code[9:0] == $past(code_q) && o_word2_code[15:10] == 6'h00;
  endproperty
  a_code_word: assert property (p_code_word) else $error("code word wrong"); // see R8

  property p_cal_zero;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      i_auto_zero_calibration |=> o_word0_temp == 16'h0000;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("temp not zero"); // see R10

  property p_clear_fall;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (clr_q == CLR_ARMED && !i_error_clear_request && !i_err.valid) |=> cls_q == CLS_NONE;
  endproperty
  a_clear_fall: assert property (p_clear_fall) else $error("clear not done"); // see R15

  property p_clear_hold;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_error_clear_request && cls_q != CLS_NONE) |=> cls_q != CLS_NONE;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("cleared too early"); // see R15

  property p_toggle_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (warn_live && slow_ph_q) |=> o_aout_mv == MV_FULL;
  endproperty
  a_toggle_full: assert property (p_toggle_full) else $error("no full scale"); // see R12

  property p_start_hold;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (cls_q != CLS_NONE && !warn_live) |=> o_aout_mv == $past(level);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("level not held"); // see R13

  property p_warn_flag;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      ((cls_q == CLS_FAST || cls_q == CLS_SLOW) && !start_seen_q) |=> o_status.warning_flag;
  endproperty
  a_warn_flag: assert property (p_warn_flag) else $error("warning flag missing"); // see R7

  property p_relay_start;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      ((cls_q == CLS_FAST || cls_q == CLS_SLOW) && start_seen_q && !i_relay_inverted)
        |=> o_alarm_relay;
  endproperty
  a_relay_start: assert property (p_relay_start) else $error("relay off after start"); // see R4

  property p_relay_inv_warn;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (warn_live && i_relay_inverted) |=> o_alarm_relay;
  endproperty
  a_relay_inv_warn: assert property (p_relay_inv_warn) else $error("relay not inverted"); // see R6

  property p_level_low;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (warn_live && !slow_ph_q) |=> o_aout_mv == $past(level);
  endproperty
  a_level_low: assert property (p_level_low) else $error("no error level half"); // see R12

  // A report landing in the clearing cycle must not be lost to the clear
  property p_set_wins;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (clear_now && new_cls != CLS_NONE) |=> cls_q != CLS_NONE && code_q == $past(i_err.code);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("report lost in clear"); // see R14

  property p_steady_level;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      cls_q == CLS_STEADY |=> o_aout_mv == $past(level) && !o_status.warning_flag;
  endproperty
  a_steady_level: assert property (p_steady_level) else $error("fault level wrong"); // see R11

endmodule

/* File: rtl/aei_pkg.sv */
// Constants, types and helpers for the alarm and error indicator
// Behaviour
// R1: Lamp blinks at 4 Hz for zero-calibration warnings 104-106, 211, 302, 303.
// R2: Lamp blinks at 1 Hz for configuration errors 111-114; the code also blinks 115 and 116 at 1 Hz.
// R3: Lamp lit steadily for start-blocking faults, including all 9xx codes.
// R4: Factory polarity: relay off while blinking, on once start arrives.
// R5: Factory polarity: relay on for any steady start-blocking fault.
// R6: Inverted polarity setting inverts every relay state; the code still resets the relay to 0 whatever the setting.
// R7: Any error sets alarm_flag; warnings also set warning_flag.
// R8: Active error code sits in bits 0 to 9 of word two.
// R9: Word zero carries temperature, signed 16 bit, 1 degree per count.
// R10: Reported temperature is zero during calibration or any fault.
// R11: During an error the analogue output shows the code's error level.
// R12: Warning codes toggle the output at 1 Hz between level and 10 V.
// R13: Start during a toggling warning freezes the output at the level.
// R14: Errors clear by error_clear_request or by power cycle (reset).
// R15: Clear by request completes only when the request bit falls.
// R16: The PLC must filter error reports seen during power-down.
// R17: Codes 101, 102, 103 give 0.66 V, 1.33 V, 2.00 V.
// R18: Codes 107, 108, 307-310 give 2.66 V.
// R19: Codes 201-203 give 3.33 V.
// R20: Codes 304 and 305 give 4.00 V.
// R21: All 9xx codes give 4.66 V.
// R22: Full three-digit code is kept and reported, whatever the level.
// R23: Codes 104-106, 302, 303 give 5.33 V; code 211 gives 6.00 V.
// R24: 111 gives 6.66, 112 7.33, 113/114 8.00, 115/116 8.66 V.
// R25: Blink and toggle waves have 50 percent duty, from clock dividers.
// R26: Highest class wins, steady over warnings, held until cleared.
package aei_pkg;

  // Clock and blink timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_HALF_MS  = 125;
  localparam int SLOW_HALF_MS  = 500;
  localparam int FAST_HALF_CYC = FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // Word layout
  localparam int CODE_LSB = 0;
  localparam int CODE_W   = 10;

  // Analogue output in millivolts
  localparam logic [13:0] MV_FULL  = 14'd10000;
  localparam logic [13:0] MV_0_66  = 14'd660;
  localparam logic [13:0] MV_1_33  = 14'd1330;
  localparam logic [13:0] MV_2_00  = 14'd2000;
  localparam logic [13:0] MV_2_66  = 14'd2660;
  localparam logic [13:0] MV_3_33  = 14'd3330;
  localparam logic [13:0] MV_4_00  = 14'd4000;
  localparam logic [13:0] MV_4_66  = 14'd4660;
  localparam logic [13:0] MV_5_33  = 14'd5330;
  localparam logic [13:0] MV_6_00  = 14'd6000;
  localparam logic [13:0] MV_6_66  = 14'd6660;
  localparam logic [13:0] MV_7_33  = 14'd7330;
  localparam logic [13:0] MV_8_00  = 14'd8000;
  localparam logic [13:0] MV_8_66  = 14'd8660;
  // Millivolts per degree, times 256, for 300 and 500 degree ranges
  localparam logic [15:0] SCALE_300 = 16'h2155;
  localparam logic [15:0] SCALE_500 = 16'h1400;

  // Reset values
  localparam logic [9:0]  CODE_RST = 10'h000;
  localparam logic [13:0] MV_RST   = 14'h0000;

  // Alarm classes, one-hot
  typedef enum logic [3:0] {
    CLS_NONE   = 4'b0001,
    CLS_FAST   = 4'b0010,
    CLS_SLOW   = 4'b0100,
    CLS_STEADY = 4'b1000
  } aei_cls_t;

  // Status bits of the cyclic data
  typedef struct packed {
    logic [12:0] rsvd;
    logic        standby_flag;
    logic        warning_flag;
    logic        alarm_flag;
  } aei_status_t;

  // Incoming error report
  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } aei_err_t;

  // Class of an error code
  function automatic aei_cls_t cls_of(input logic [9:0] c);
    if ((c >= 10'd104 && c <= 10'd106) || c == 10'd211 || c == 10'd302 || c == 10'd303)
      return CLS_FAST;
    if (c >= 10'd111 && c <= 10'd116)
      return CLS_SLOW;
    if ((c >= 10'd101 && c <= 10'd103) || c == 10'd107 || c == 10'd108
        || (c >= 10'd201 && c <= 10'd203) || (c >= 10'd304 && c <= 10'd310 && c != 10'd306)
        || (c >= 10'd900 && c <= 10'd999))
      return CLS_STEADY;
    return CLS_NONE;
  endfunction

  // Rank used to pick the dominant error
  function automatic logic [1:0] rank_of(input aei_cls_t k);
    case (k)
      CLS_STEADY: return 2'd3;
      CLS_SLOW:   return 2'd2;
      CLS_FAST:   return 2'd1;
      default:    return 2'd0;
    endcase
  endfunction

endpackage

/* File: rtl/aei_half_div.sv */
// Half-period divider giving a one-cycle enable per half wave
`timescale 1ns/1ps
module aei_half_div #(
  parameter int HALF_CYC = 4
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // Enable pulse
  output logic      o_tick
);

  logic [31:0] cnt_q;

  // Free-running count so every half wave has the same length
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 32'h00000000;
      o_tick <= 1'b0;
    end else if (cnt_q == 32'(HALF_CYC - 1)) begin
      cnt_q  <= 32'h00000000;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h00000001;
      o_tick <= 1'b0;
    end
  end

endmodule

/* File: test/aei_plc_model.sv */
// Higher-level controller model latching error codes from the cyclic data
`timescale 1ns/1ps
module aei_plc_model
  import aei_pkg::*;
(
  // Clock
  input  wire logic        i_clk_sys,
  // Cyclic data from the device
  input  wire aei_status_t i_status,
  input  wire logic [15:0] i_word2_code,
  // Device supply going down
  input  wire logic        i_powering_down,
  // Last error code accepted
  output logic [15:0]      o_code_seen
);
  initial o_code_seen = 16'h0000;

  // Reports seen while the device powers down may be bogus, so they are dropped
  always @(posedge i_clk_sys) begin
    if (i_status.alarm_flag === 1'b1 && !i_powering_down) begin
      o_code_seen <= i_word2_code;
    end
  end
endmodule

/* File: test/tb_aei_alarm_top.sv */
// Self-checking bench for the alarm and error indicator
`timescale 1ns/1ps
module tb_aei_alarm_top import aei_pkg::*;;
  // Short blink counts keep the run brief
  localparam int FH = 4;
  localparam int SH = 16;

  logic        clk, rstn, start, clr, cal, stby, inv, r500, pd;
  aei_err_t    err;
  logic [15:0] temp, word0, word2, plc_code;
  aei_status_t status;
  logic        lamp, relay;
  logic [13:0] aout;
  int          n_fail, samples_checked;

  aei_alarm_top #(.FAST_HALF(FH), .SLOW_HALF(SH)) u_dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_err(err), .i_start(start),
    .i_error_clear_request(clr), .i_auto_zero_calibration(cal), .i_standby_flag(stby),
    .i_relay_inverted(inv), .i_range_500(r500), .i_temp_c(temp), .o_alarm_lamp(lamp),
    .o_alarm_relay(relay), .o_word0_temp(word0), .o_status(status),
    .o_word2_code(word2), .o_aout_mv(aout));

  aei_plc_model u_plc (
    .i_clk_sys(clk), .i_status(status), .i_word2_code(word2),
    .i_powering_down(pd), .o_code_seen(plc_code));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Wait edges, then sample on the falling edge where outputs are settled
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // One-cycle error report; outputs are valid one edge after it is taken
  task automatic report(input logic [9:0] c);
    @(posedge clk);
    err <= {1'b1, c};
    @(posedge clk);
    err <= '0;
    edges(1);
  endtask

  task automatic clear_err(input int hold);
    @(posedge clk);
    clr <= 1'b1;
    repeat (hold) @(posedge clk);
    clr <= 1'b0;
    edges(2);
  endtask

  task automatic t_temp();
    @(posedge clk);
    temp <= 16'hFFFB;
    edges(2);
    chk(word0, 16'hFFFB, "signed temp");
    chk(relay, 16'h0, "relay idle");
    chk(aout, 16'h0, "aout below zero");
    @(posedge clk);
    cal <= 1'b1;
    edges(2);
    chk(word0, 16'h0, "temp in calibration");
    @(posedge clk);
    cal  <= 1'b0;
    stby <= 1'b1;
    edges(2);
    chk(aout, 16'h0, "aout standby");
    chk(status.standby_flag, 16'h1, "standby flag");
    @(posedge clk);
    stby <= 1'b0;
    temp <= 16'h0019;
    edges(2);
    chk(aout, 16'h0341, "aout 25 C on 300 C span");
    @(posedge clk);
    r500 <= 1'b1;
    edges(2);
    chk(aout, 16'h01F4, "aout 25 C on 500 C span");
    @(posedge clk);
    r500 <= 1'b0;
  endtask

  task automatic t_steady();
    // 101 102 103 107 108 307 308 309 310 201 202 203 304 305 901 918
    logic [9:0]  c[16] = '{10'h065, 10'h066, 10'h067, 10'h06B, 10'h06C, 10'h133, 10'h134,
                           10'h135, 10'h136, 10'h0C9, 10'h0CA, 10'h0CB, 10'h130, 10'h131,
                           10'h385, 10'h396};
    logic [13:0] v[16] = '{MV_0_66, MV_1_33, MV_2_00, MV_2_66, MV_2_66, MV_2_66, MV_2_66,
                           MV_2_66, MV_2_66, MV_3_33, MV_3_33, MV_3_33, MV_4_00, MV_4_00,
                           MV_4_66, MV_4_66};
    for (int i = 0; i < 16; i++) begin
      report(c[i]);
      chk(lamp, 16'h1, "lamp steady");
      chk(relay, 16'h1, "relay steady");
      chk(status.alarm_flag, 16'h1, "alarm flag");
      chk(status.warning_flag, 16'h0, "no warning");
      chk(word2, 16'(c[i]), "code word");
      chk(word0, 16'h0, "temp on fault");
      chk(aout, 16'(v[i]), "fault level");
      clear_err(1);
      chk(status.alarm_flag, 16'h0, "cleared");
      chk(lamp, 16'h0, "lamp off");
    end
  endtask

  task automatic t_warn();
    // 104 105 106 302 303 211 111 112 113 114 115 116
    logic [9:0]  c[12] = '{10'h068, 10'h069, 10'h06A, 10'h12E, 10'h12F, 10'h0D3, 10'h06F,
                           10'h070, 10'h071, 10'h072, 10'h073, 10'h074};
    logic [13:0] v[12] = '{MV_5_33, MV_5_33, MV_5_33, MV_5_33, MV_5_33, MV_6_00, MV_6_66,
                           MV_7_33, MV_8_00, MV_8_00, MV_8_66, MV_8_66};
    int   nh, tr, nf, nl, nb;
    logic prev;
    for (int i = 0; i < 12; i++) begin
      report(c[i]);
      chk(relay, 16'h0, "relay warn");
      chk(status.warning_flag, 16'h1, "warning flag");
      chk(word2, 16'(c[i]), "warn code");
      nh = 0; tr = 0; nf = 0; nl = 0;
      prev = lamp;
      repeat (64) begin
        @(negedge clk);
        tr += int'(lamp !== prev);
        prev = lamp;
        nh += int'(lamp === 1'b1);
        nf += int'(aout === MV_FULL);
        nl += int'(aout === v[i]);
      end
      chk(16'(nh), 16'h20, "lamp duty");
      chk(16'(tr), (i < 6) ? 16'h10 : 16'h4, "blink rate");
      chk(16'(nf), 16'h20, "aout full half");
      chk(16'(nl), 16'h20, "aout level half");
      @(posedge clk);
      start <= 1'b1;
      edges(2);
      chk(relay, 16'h1, "relay started");
      chk(status.warning_flag, 16'h0, "warning gone");
      nb = 0;
      repeat (40) begin
        @(negedge clk);
        nb += int'(aout !== v[i] || lamp !== 1'b1);
      end
      chk(16'(nb), 16'h0, "frozen level");
      @(posedge clk);
      start <= 1'b0;
      clear_err(1);
    end
  endtask

  task automatic t_prio();
    report(10'h068);
    report(10'h065);
    chk(word2, 16'h0065, "steady beats warn");
    report(10'h06F);
    report(10'h066);
    chk(word2, 16'h0065, "first kept");
    chk(aout, 16'(MV_0_66), "level kept");
    @(posedge clk);
    clr <= 1'b1;
    edges(8);
    chk(status.alarm_flag, 16'h1, "held while set");
    @(posedge clk);
    clr <= 1'b0;
    edges(2);
    chk(status.alarm_flag, 16'h0, "clear on fall");
    // Equal-rank report in the clearing cycle replaces the held one
    report(10'h065);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    err <= {1'b1, 10'h066};
    @(posedge clk);
    err <= '0;
    edges(1);
    chk(word2, 16'h0066, "report in clear cycle kept");
    clear_err(1);
    report(10'h132);
    chk(status.alarm_flag, 16'h0, "code 306 ignored");
  endtask

  task automatic t_inv();
    @(posedge clk);
    inv <= 1'b1;
    edges(2);
    chk(relay, 16'h1, "inv idle");
    report(10'h065);
    chk(relay, 16'h0, "inv steady");
    clear_err(1);
    report(10'h068);
    chk(relay, 16'h1, "inv warn");
    @(posedge clk);
    start <= 1'b1;
    edges(2);
    chk(relay, 16'h0, "inv started");
    @(posedge clk);
    start <= 1'b0;
    inv   <= 1'b0;
    clear_err(1);
  endtask

  task automatic t_pwr();
    report(10'h391);
    edges(1);
    chk(plc_code, 16'h0391, "plc code");
    @(posedge clk);
    pd   <= 1'b1;
    rstn <= 1'b0;
    edges(2);
    @(posedge clk);
    rstn <= 1'b1;
    edges(2);
    chk(status.alarm_flag, 16'h0, "power cycle clear");
    report(10'h065);
    edges(1);
    chk(plc_code, 16'h0391, "plc ignores");
    @(posedge clk);
    pd <= 1'b0;
    edges(2);
    chk(plc_code, 16'h0065, "plc accepts");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 1600 cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    n_fail = 0; samples_checked = 0;
    rstn = 1'b0; start = 1'b0; clr = 1'b0; cal = 1'b0; stby = 1'b0;
    inv = 1'b0; r500 = 1'b0; pd = 1'b0; err = '0; temp = 16'h0000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    edges(1);
    t_temp();
    t_steady();
    t_warn();
    t_prio();
    t_inv();
    t_pwr();
    summarize();
  end
endmodule
